// ---- dv/clk_cfg_assertions.sv ----
`timescale 1ns/1ps
`include "clk_cfg_defines.svh"
module clk_cfg_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire clk_cfg_pkg::reg_req_type reg_req_in,
  input wire logic [31:0] rdata_out,
  input wire logic [31:0] peripheral_clk_running_in,
  input wire logic main_osc_enable_out,
  input wire logic osc_bypass_select_out,
  input wire logic main_osc_stable_flag_out,
  input wire logic pll_a_lock_flag_out,
  input wire logic pll_b_lock_flag_out,
  input wire clk_cfg_pkg::pll_drive_type pll_a_drive_out,
  input wire clk_cfg_pkg::pll_drive_type pll_b_drive_out,
  input wire logic [1:0] master_source_select_out,
  input wire logic cpu_tick_out,
  input wire logic master_tick_out,
  input wire logic usb_tick_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  periph_read_a:
  assert property (reg_req_in.rd && reg_req_in.addr == `OFF_PERIPH_STATUS
    |=> rdata_out == ($past(peripheral_clk_running_in) & `MASK_PERIPH))
    else $error("periph status read wrong");
  bypass_stable_a:
  assert property (osc_bypass_select_out |-> ##[0:2] main_osc_stable_flag_out)
    else $error("bypass did not set stable");
  stable_clear_a:
  assert property ((!main_osc_enable_out && !osc_bypass_select_out) [*2]
    |-> !main_osc_stable_flag_out) else $error("stable not cleared");
  stable_source_a:
  assert property (main_osc_stable_flag_out
    |-> $past(main_osc_enable_out || osc_bypass_select_out))
    else $error("stable without oscillator");
  lock_a_clear_a:
  assert property (reg_req_in.wr && reg_req_in.addr == `OFF_PLL_A
    |=> !pll_a_lock_flag_out) else $error("lock a not cleared");
  lock_b_clear_a:
  assert property (reg_req_in.wr && reg_req_in.addr == `OFF_PLL_B
    |=> !pll_b_lock_flag_out) else $error("lock b not cleared");
  mult_a_off_a:
  assert property (pll_a_drive_out.multiplier == 11'h0
    |-> !pll_a_drive_out.active) else $error("pll a active at zero");
  mult_b_off_a:
  assert property (pll_b_drive_out.multiplier == 11'h0
    |-> !pll_b_drive_out.active) else $error("pll b active at zero");
  usb_gated_a:
  assert property (!pll_b_drive_out.active [*4] |-> !usb_tick_out)
    else $error("usb tick without pll b");
  cpu_pulse_a:
  assert property (cpu_tick_out |=> !cpu_tick_out)
    else $error("cpu tick too long");
  master_sub_a:
  assert property (master_tick_out |-> cpu_tick_out || $past(cpu_tick_out))
    else $error("master tick without cpu tick");
  source_write_a:
  assert property (reg_req_in.wr && reg_req_in.addr == `OFF_MASTER
    |=> master_source_select_out == $past(reg_req_in.wdata[1:0]))
    else $error("source select not taken");
endmodule

bind oscillator_pll_master_clock_config clk_cfg_checker chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
  .rdata_out(rdata_out),
  .peripheral_clk_running_in(peripheral_clk_running_in),
  .main_osc_enable_out(main_osc_enable_out),
  .osc_bypass_select_out(osc_bypass_select_out),
  .main_osc_stable_flag_out(main_osc_stable_flag_out),
  .pll_a_lock_flag_out(pll_a_lock_flag_out),
  .pll_b_lock_flag_out(pll_b_lock_flag_out),
  .pll_a_drive_out(pll_a_drive_out), .pll_b_drive_out(pll_b_drive_out),
  .master_source_select_out(master_source_select_out),
  .cpu_tick_out(cpu_tick_out), .master_tick_out(master_tick_out),
  .usb_tick_out(usb_tick_out));

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`include "clk_cfg_defines.svh"
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  clk_cfg_pkg::reg_req_type req = '0;
  clk_cfg_pkg::pll_drive_type dra, drb;
  logic [31:0] rdata_out, d;
  logic [31:0] periph = 32'h0;
  logic [4:0] ph = 5'h0;
  logic [4:0] tk;
  logic [2:0] fl;
  logic en, byp, stab, lka, lkb, cpu_t, mst_t, usb_t;
  logic [1:0] src_sel;
  int error_cnt = 0;
  int check_count = 0;
  int cnt [5] = '{default: 0};
  int c0;
  int se [4] = '{30, 120, 240, 60};
  logic [7:0] ra [7] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h68, 8'h40};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h3f00, 32'h3f00, 32'h0, 32'h8,
    32'h0};

  oscillator_pll_master_clock_config dut_u (.clk_in(clk_in),
    .rst_in(rst_in), .reg_req_in(req), .rdata_out(rdata_out),
    .slow_clk_in(ph[4]), .main_clk_in(ph[2]), .pll_a_clk_in(ph[1]),
    .pll_b_clk_in(ph[3]), .peripheral_clk_running_in(periph),
    .main_osc_enable_out(en), .osc_bypass_select_out(byp),
    .main_osc_stable_flag_out(stab), .pll_a_lock_flag_out(lka),
    .pll_b_lock_flag_out(lkb), .pll_a_drive_out(dra),
    .pll_b_drive_out(drb), .master_source_select_out(src_sel),
    .cpu_tick_out(cpu_t), .master_tick_out(mst_t), .usb_tick_out(usb_t));

  assign tk = {drb.ref_tick, dra.ref_tick, usb_t, mst_t, cpu_t};
  assign fl = {lkb, lka, stab};

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // Pin clocks: slow 32, pll b 16, main 8, pll a 4 cycles a period
  always @(posedge clk_in) begin
    ph <= ph + 5'h1;
    for (int i = 0; i < 5; i++) if (tk[i] === 1'b1) cnt[i]++;
  end

  task automatic chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic rng(input string n, input int lo, hi, s);
    check_count++;
    if (s < lo || s > hi) begin
      error_cnt++;
      $display("BAD %s exp %0d..%0d seen %0d", n, lo, hi, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    req <= {a, v, 2'b10};
    @(posedge clk_in);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    req <= {a, 32'h0, 2'b01};
    @(posedge clk_in);
    req <= '0;
    #1 d = rdata_out;
  endtask

  task automatic win(input int i, lo, hi);
    // Let ticks launched under the old setting drain first
    repeat (2) @(posedge clk_in);
    c0 = cnt[i];
    repeat (960) @(posedge clk_in);
    #1 rng("ticks", lo, hi, cnt[i] - c0);
  endtask

  task automatic wt(input int b, lo, hi);
    c0 = 0;
    #1;
    while (fl[b] !== 1'b1 && c0 < 600) begin
      @(posedge clk_in);
      #1 c0++;
    end
    rng("flag delay", lo, hi, c0);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", rv[i], d);
    end
    $display("test reset done");
    @(posedge clk_in);
    periph <= 32'ha5a5_5a5f;
    rd(`OFF_PERIPH_STATUS);
    chk("periph", 32'ha5a5_5a5c, d);
    $display("test periph done");
    wr(`OFF_OSC_CTRL, 32'h2);
    repeat (2) @(posedge clk_in);
    #1 chk("bypass stable", 32'h1, 32'(stab));
    chk("bypass out", 32'h1, 32'(byp));
    wr(`OFF_OSC_CTRL, 32'h0);
    repeat (2) @(posedge clk_in);
    #1 chk("off stable", 32'h0, 32'(stab));
    wr(`OFF_OSC_CTRL, 32'h0101);
    wt(0, 220, 266);
    chk("osc enable", 32'h1, 32'(en));
    chk("osc no bypass", 32'h0, 32'(byp));
    repeat (600) @(posedge clk_in);
    rd(`OFF_MEASURE);
    chk("first measure", 32'h0001_0040, d);
    repeat (500) @(posedge clk_in);
    rd(`OFF_MEASURE);
    chk("measure", 32'h0001_0040, d);
    wr(`OFF_OSC_CTRL, 32'h0);
    repeat (3) @(posedge clk_in);
    rd(`OFF_MEASURE);
    chk("measure valid", 32'h0, 32'(d[16]));
    $display("test osc done");
    wr(`OFF_PLL_A, 32'h2002_0201);
    wt(1, 30, 72);
    rd(`OFF_PLL_A);
    chk("pll a", 32'h2002_0201, d);
    chk("pll a drive", 32'h802, {dra.active, dra.multiplier});
    win(3, 119, 121);
    wr(`OFF_PLL_A, 32'h2002_8203);
    win(3, 39, 41);
    chk("pll a range", 32'h2, 32'(dra.range));
    wr(`OFF_PLL_A, 32'h2002_0200);
    win(3, 0, 0);
    chk("pll a off", 32'h0, 32'(dra.active));
    wr(`OFF_PLL_A, 32'h2000_0201);
    #1 chk("pll a mult0", 32'h0, 32'(dra.active));
    $display("test pll a done");
    wr(`OFF_PLL_B, 32'h0001_4104);
    wt(2, 1, 45);
    rd(`OFF_PLL_B);
    chk("pll b", 32'h0001_4104, d);
    chk("pll b range", 32'h1, 32'(drb.range));
    win(4, 29, 31);
    for (int k = 0; k < 3; k++) begin
      wr(`OFF_PLL_B, {2'b00, k[1:0], 28'h001_0101});
      win(2, (60 >> k) - 1, (60 >> k) + 1);
    end
    wr(`OFF_PLL_B, 32'h0000_0101);
    win(2, 0, 0);
    chk("pll b mult0", 32'h0, 32'(drb.active));
    $display("test pll b done");
    wr(`OFF_PLL_B, 32'h0001_0101);
    wr(`OFF_PLL_A, 32'h2002_0201);
    for (int k = 0; k < 4; k++) begin
      wr(`OFF_MASTER, 32'(k));
      #1 chk("source", 32'(k), 32'(src_sel));
      win(0, se[k] - 1, se[k] + 1);
    end
    for (int k = 0; k < 3; k++) begin
      wr(`OFF_MASTER, 32'h2 | (32'(k) << 8));
      win(1, (240 >> k) - 1, (240 >> k) + 1);
    end
    for (int k = 0; k < 7; k++) begin
      wr(`OFF_MASTER, {27'h0, k[2:0], 2'b10});
      win(0, (240 >> k) - 1, (240 >> k) + 1);
    end
    $display("test master done");
    close_out();
  end
endmodule

// ---- rtl/clk_cfg_defines.svh ----
`ifndef CLK_CFG_DEFINES_SVH
`define CLK_CFG_DEFINES_SVH

// Register offsets
`define OFF_PERIPH_STATUS 8'h18
`define OFF_OSC_CTRL 8'h20
`define OFF_MEASURE 8'h24
`define OFF_PLL_A 8'h28
`define OFF_PLL_B 8'h2c
`define OFF_MASTER 8'h30
`define OFF_STATUS 8'h68

// Reset values
`define RST_OSC_CTRL 32'h0000_0000
`define RST_PLL 32'h0000_3f00
`define RST_MASTER 32'h0000_0000

// Writable bits of each config register, and the periph status read mask
`define MASK_OSC_CTRL 32'h0000_ff03
`define MASK_PLL_A 32'h27ff_ffff
`define MASK_PLL_B 32'h37ff_ffff
`define MASK_MASTER 32'h0000_031f
`define MASK_PERIPH 32'hffff_fffc

// Field positions
`define MEASURE_VALID_BIT 16
`define ST_OSC_STABLE_BIT 0
`define ST_LOCK_A_BIT 1
`define ST_LOCK_B_BIT 2
`define ST_MASTER_READY_BIT 3

// Start-up count shift (times eight) and measure window count in slow clock periods
`define OSC_STARTUP_SHIFT 3
`define MEASURE_SLOW_PERIODS 16

// Reserved codes
`define CPU_DIV_RESERVED 3'h7
`define DIV2_RESERVED 2'h3

`endif

// ---- rtl/clk_cfg_pkg.sv ----
package clk_cfg_pkg;

  typedef struct packed {
    logic [15:0] unused_hi;
    logic [7:0] osc_startup_count;
    logic [5:0] unused_lo;
    logic osc_bypass_select;
    logic main_osc_enable;
  } osc_cfg_type;

  typedef struct packed {
    logic [1:0] unused_top;
    logic [1:0] usb_clock_divider;
    logic unused_gap;
    logic [10:0] multiplier;
    logic [1:0] range;
    logic [5:0] lock_count;
    logic [7:0] input_divider;
  } pll_cfg_type;

  typedef struct packed {
    logic [21:0] unused_hi;
    logic [1:0] master_divider;
    logic [2:0] unused_mid;
    logic [2:0] cpu_clock_divide_ratio;
    logic [1:0] master_source_select;
  } master_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic active;
    logic [10:0] multiplier;
    logic [1:0] range;
    logic ref_tick;
  } pll_drive_type;

  typedef enum logic [1:0] {
    osc_off,
    osc_starting,
    osc_stable
  } osc_state_type;

endpackage

// ---- rtl/oscillator_pll_master_clock_config.sv ----
// How it works
// - Peripheral status bits 31:2 read clock running state; bits 1:0 read zero
// - Enable bit starts oscillator; bypass kept low
// - Stable flag rises after start-up interval
// - Bypass sets stable flag at once
// - Enable and bypass both low clear stable
// - Start-up interval is count times eight slow
// - Measure counts main cycles in sixteen slow
// - Measure valid only with oscillator on, counted
// - PLL A divider: off, bypass, divide by N
// - PLL A lock after programmed slow cycles
// - PLL A multiplier zero deactivates, else times N+1
// - PLL B divider: off, bypass, divide by N
// - PLL B lock after programmed slow cycles
// - PLL B multiplier zero deactivates, else times N+1
// - USB divider passes, halves or quarters PLL B
// - Source select: slow, main, PLL A, PLL B
// - Processor prescaler divides by powers of two
// - Master divider gives one, half or quarter
// - Stable flag reads one when oscillator stabilized
// - PLL A lock flag reads locked state
`timescale 1ns/1ps
`include "clk_cfg_defines.svh"

module oscillator_pll_master_clock_config #(
  parameter int NUM_PLL = 2,
  parameter int NUM_DIV = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire clk_cfg_pkg::reg_req_type reg_req_in,
  output logic [31:0] rdata_out,
  input wire logic slow_clk_in,
  input wire logic main_clk_in,
  input wire logic pll_a_clk_in,
  input wire logic pll_b_clk_in,
  input wire logic [31:0] peripheral_clk_running_in,
  output logic main_osc_enable_out,
  output logic osc_bypass_select_out,
  output logic main_osc_stable_flag_out,
  output logic pll_a_lock_flag_out,
  output logic pll_b_lock_flag_out,
  output clk_cfg_pkg::pll_drive_type pll_a_drive_out,
  output clk_cfg_pkg::pll_drive_type pll_b_drive_out,
  output logic [1:0] master_source_select_out,
  output logic cpu_tick_out,
  output logic master_tick_out,
  output logic usb_tick_out
);

  // Power-of-two divide code to terminal count
  function automatic logic [7:0] pow2_tc(input logic [2:0] code);
    pow2_tc = (8'h01 << code) - 8'h01;
  endfunction

  // Pin synchronisers and rising edge ticks
  logic [3:0] pin_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] pin_tick;
  logic slow_tick;
  logic main_tick;

  assign pin_raw = {pll_b_clk_in, pll_a_clk_in, main_clk_in, slow_clk_in};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
        end
      end
      assign pin_tick[g] = sync2_q[g] & ~sync3_q[g];
    end
  endgenerate

  assign slow_tick = pin_tick[0];
  assign main_tick = pin_tick[1];

  // Register decode
  logic wr_osc;
  logic wr_master;
  logic [NUM_PLL-1:0] wr_pll;

  assign wr_osc = reg_req_in.wr && reg_req_in.addr == `OFF_OSC_CTRL;
  assign wr_master = reg_req_in.wr && reg_req_in.addr == `OFF_MASTER;
  assign wr_pll[0] = reg_req_in.wr && reg_req_in.addr == `OFF_PLL_A;
  assign wr_pll[1] = reg_req_in.wr && reg_req_in.addr == `OFF_PLL_B;

  // Oscillator control register
  clk_cfg_pkg::osc_cfg_type osc_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_q <= clk_cfg_pkg::osc_cfg_type'(`RST_OSC_CTRL);
    end else if (wr_osc) begin
      osc_q <= clk_cfg_pkg::osc_cfg_type'(
        reg_req_in.wdata & `MASK_OSC_CTRL);
    end
  end

  // Oscillator start-up sequencer
  clk_cfg_pkg::osc_state_type osc_state_q;
  logic [10:0] startup_cnt_q;
  logic [10:0] startup_target;
  logic osc_on;

  assign startup_target =
    {3'h0, osc_q.osc_startup_count} << `OSC_STARTUP_SHIFT;
  assign osc_on = osc_q.main_osc_enable | osc_q.osc_bypass_select;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_state_q <= clk_cfg_pkg::osc_off;
      startup_cnt_q <= 11'h000;
    end else begin
      unique case (osc_state_q)
        clk_cfg_pkg::osc_off: begin
          startup_cnt_q <= 11'h000;
          if (osc_q.osc_bypass_select) begin
            osc_state_q <= clk_cfg_pkg::osc_stable;
          end else if (osc_q.main_osc_enable) begin
            osc_state_q <= clk_cfg_pkg::osc_starting;
          end
        end
        clk_cfg_pkg::osc_starting: begin
          if (!osc_on) begin
            osc_state_q <= clk_cfg_pkg::osc_off;
          end else if (osc_q.osc_bypass_select) begin
            osc_state_q <= clk_cfg_pkg::osc_stable;
          end else if (startup_cnt_q >= startup_target) begin
            osc_state_q <= clk_cfg_pkg::osc_stable;
          end else if (slow_tick) begin
            startup_cnt_q <= startup_cnt_q + 11'h001;
          end
        end
        clk_cfg_pkg::osc_stable: begin
          if (!osc_on) begin
            osc_state_q <= clk_cfg_pkg::osc_off;
          end
        end
      endcase
    end
  end

  assign main_osc_stable_flag_out =
    osc_state_q == clk_cfg_pkg::osc_stable;
  assign main_osc_enable_out = osc_q.main_osc_enable;
  assign osc_bypass_select_out = osc_q.osc_bypass_select;

  // Main clock frequency measurement
  logic [3:0] window_q;
  logic [15:0] main_cnt_q;
  logic [15:0] freq_q;
  logic freq_valid_q;
  logic meas_armed_q;
  logic [15:0] main_cnt_next;

  assign main_cnt_next = main_cnt_q + {15'h0000, main_tick};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      window_q <= 4'h0;
      main_cnt_q <= 16'h0000;
      freq_q <= 16'h0000;
      freq_valid_q <= 1'b0;
      meas_armed_q <= 1'b0;
    end else if (!main_osc_stable_flag_out) begin
      window_q <= 4'h0;
      main_cnt_q <= 16'h0000;
      meas_armed_q <= 1'b0;
      if (!osc_on) begin
        freq_valid_q <= 1'b0;
      end
    end else if (!meas_armed_q) begin
      // Open the window on a slow edge so it spans whole periods
      meas_armed_q <= slow_tick;
    end else if (slow_tick) begin
      window_q <= window_q + 4'h1;
      if (window_q == 4'(`MEASURE_SLOW_PERIODS - 1)) begin
        freq_q <= main_cnt_next;
        freq_valid_q <= 1'b1;
        main_cnt_q <= 16'h0000;
      end else begin
        main_cnt_q <= main_cnt_next;
      end
    end else begin
      main_cnt_q <= main_cnt_next;
    end
  end

  // PLL configuration and lock counters
  clk_cfg_pkg::pll_cfg_type pll_q [NUM_PLL];
  logic [5:0] lock_cnt_q [NUM_PLL];
  logic [NUM_PLL-1:0] lock_q;
  logic [NUM_PLL-1:0] pll_active;
  logic [NUM_PLL-1:0] pll_tick;
  logic [31:0] pll_mask [NUM_PLL];

  assign pll_mask[0] = `MASK_PLL_A;
  assign pll_mask[1] = `MASK_PLL_B;

  generate
    for (g = 0; g < NUM_PLL; g++) begin : g_pll
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          pll_q[g] <= clk_cfg_pkg::pll_cfg_type'(`RST_PLL);
        end else if (wr_pll[g]) begin
          pll_q[g] <= clk_cfg_pkg::pll_cfg_type'(
            reg_req_in.wdata & pll_mask[g]);
        end
      end

      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          // Start from the reset count so lock stays low after reset
          lock_cnt_q[g] <= 6'(`RST_PLL >> 8);
          lock_q[g] <= 1'b0;
        end else if (wr_pll[g]) begin
          lock_cnt_q[g] <= reg_req_in.wdata[13:8];
          lock_q[g] <= 1'b0;
        end else if (!lock_q[g]) begin
          if (lock_cnt_q[g] == 6'h00) begin
            lock_q[g] <= 1'b1;
          end else if (slow_tick) begin
            lock_cnt_q[g] <= lock_cnt_q[g] - 6'h01;
          end
        end
      end

      // Zero multiplier or zero input divider stops the PLL
      assign pll_active[g] = pll_q[g].multiplier != 11'h000 &&
        pll_q[g].input_divider != 8'h00;
      assign pll_tick[g] = pin_tick[g+2] & pll_active[g];
    end
  endgenerate

  assign pll_a_lock_flag_out = lock_q[0];
  assign pll_b_lock_flag_out = lock_q[1];

  // Master clock configuration
  clk_cfg_pkg::master_cfg_type mck_q;
  logic mck_ready_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mck_q <= clk_cfg_pkg::master_cfg_type'(`RST_MASTER);
    end else if (wr_master) begin
      mck_q <= clk_cfg_pkg::master_cfg_type'(
        reg_req_in.wdata & `MASK_MASTER);
    end
  end

  // Source clock tick select
  logic src_tick;

  always_comb begin
    unique case (mck_q.master_source_select)
      2'h0: src_tick = slow_tick;
      2'h1: src_tick = main_tick;
      2'h2: src_tick = pll_tick[0];
      2'h3: src_tick = pll_tick[1];
    endcase
  end

  assign master_source_select_out = mck_q.master_source_select;

  // Tick dividers: ref A, ref B, processor, master, USB
  logic [NUM_DIV-1:0] div_in;
  logic [NUM_DIV-1:0] div_en;
  logic [7:0] div_tc [NUM_DIV];
  logic [7:0] div_cnt_q [NUM_DIV];
  logic [NUM_DIV-1:0] div_out_q;

  assign div_in[0] = main_tick;
  assign div_en[0] = pll_q[0].input_divider != 8'h00;
  assign div_tc[0] = pll_q[0].input_divider - 8'h01;
  assign div_in[1] = main_tick;
  assign div_en[1] = pll_q[1].input_divider != 8'h00;
  assign div_tc[1] = pll_q[1].input_divider - 8'h01;
  assign div_in[2] = src_tick;
  assign div_en[2] =
    mck_q.cpu_clock_divide_ratio != `CPU_DIV_RESERVED;
  assign div_tc[2] = pow2_tc(mck_q.cpu_clock_divide_ratio);
  assign div_in[3] = div_out_q[2];
  assign div_en[3] = mck_q.master_divider != `DIV2_RESERVED;
  assign div_tc[3] = pow2_tc({1'b0, mck_q.master_divider});
  assign div_in[4] = pll_tick[1];
  assign div_en[4] =
    pll_q[1].usb_clock_divider != `DIV2_RESERVED;
  assign div_tc[4] = pow2_tc({1'b0, pll_q[1].usb_clock_divider});

  generate
    for (g = 0; g < NUM_DIV; g++) begin : g_div
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          div_cnt_q[g] <= 8'h00;
          div_out_q[g] <= 1'b0;
        end else if (!div_en[g]) begin
          div_cnt_q[g] <= 8'h00;
          div_out_q[g] <= 1'b0;
        end else if (div_in[g]) begin
          if (div_cnt_q[g] >= div_tc[g]) begin
            div_cnt_q[g] <= 8'h00;
            div_out_q[g] <= 1'b1;
          end else begin
            div_cnt_q[g] <= div_cnt_q[g] + 8'h01;
            div_out_q[g] <= 1'b0;
          end
        end else begin
          div_out_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign cpu_tick_out = div_out_q[2];
  assign master_tick_out = div_out_q[3];
  assign usb_tick_out = div_out_q[4];

  // Master ready drops on reconfiguration unless a master tick lands in that cycle, returns on next master tick
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mck_ready_q <= 1'b1;
    end else if (div_out_q[3]) begin
      mck_ready_q <= 1'b1;
    end else if (wr_master) begin
      mck_ready_q <= 1'b0;
    end
  end

  // Drive words toward the analog PLLs
  assign pll_a_drive_out.active = pll_active[0];
  assign pll_a_drive_out.multiplier = pll_q[0].multiplier;
  assign pll_a_drive_out.range = pll_q[0].range;
  assign pll_a_drive_out.ref_tick = div_out_q[0];
  assign pll_b_drive_out.active = pll_active[1];
  assign pll_b_drive_out.multiplier = pll_q[1].multiplier;
  assign pll_b_drive_out.range = pll_q[1].range;
  assign pll_b_drive_out.ref_tick = div_out_q[1];

  // Read path
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_req_in.addr)
      `OFF_PERIPH_STATUS:
        rd_mux = peripheral_clk_running_in & `MASK_PERIPH;
      `OFF_OSC_CTRL: rd_mux = 32'(osc_q);
      `OFF_MEASURE: begin
        rd_mux[15:0] = freq_q;
        rd_mux[`MEASURE_VALID_BIT] = freq_valid_q;
      end
      `OFF_PLL_A: rd_mux = 32'(pll_q[0]);
      `OFF_PLL_B: rd_mux = 32'(pll_q[1]);
      `OFF_MASTER: rd_mux = 32'(mck_q);
      `OFF_STATUS: begin
        rd_mux[`ST_OSC_STABLE_BIT] = main_osc_stable_flag_out;
        rd_mux[`ST_LOCK_A_BIT] = lock_q[0];
        rd_mux[`ST_LOCK_B_BIT] = lock_q[1];
        rd_mux[`ST_MASTER_READY_BIT] = mck_ready_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (reg_req_in.rd) begin
      rdata_out <= rd_mux;
    end
  end

endmodule
